// ==== core/ims_regs.vh ====
// Register offsets, field positions, reset values and constants of the interrupt mode select block.
`ifndef IMS_REGS_VH
`define IMS_REGS_VH

`define IMS_OFF_CTRL      8'h00
`define IMS_OFF_SPACING   8'h04
`define IMS_OFF_PEND      8'h08
`define IMS_OFF_MASK      8'h0C
`define IMS_OFF_MODE      8'h10
`define IMS_OFF_VECTOR    8'h14
`define IMS_OFF_IRQ_STAT  8'h18
`define IMS_OFF_IRQ_MASK  8'h1C

`define IMS_CTRL_BOOTSEL  0
`define IMS_CTRL_VECSEL   1
`define IMS_CTRL_GLBEN    2
`define IMS_CTRL_EXCLVL   3
`define IMS_CTRL_ERRLVL   4
`define IMS_CTRL_RST      5'h01

`define IMS_MODE_COMPAT   2'h0
`define IMS_MODE_VECT     2'h1
`define IMS_MODE_EXT      2'h2

`define IMS_VEC_GENERAL   12'h180
`define IMS_VEC_SPECIAL   12'h200

`define IMS_EV_RAISE      0
`define IMS_EV_MODECHG    1

`endif

// ==== core/ims_latch.v ====
// Holding register that keeps a value stable while a request is raised.
`default_nettype none

module ims_latch #(
    parameter WIDTH = 16
) (
    // Clock and reset.
    input wire clk_i,
    input wire rst_n_i,
    // Capture side.
    input wire load_i,
    input wire [WIDTH-1:0] data_i,
    // Held value.
    output wire [WIDTH-1:0] data_o
);

reg [WIDTH-1:0] hold_ff;

always @(posedge clk_i or negedge rst_n_i)
begin
    if (!rst_n_i)
    begin
        hold_ff <= {WIDTH{1'b0}};
    end
    else if (load_i)
    begin
        hold_ff <= data_i;
    end
end

assign data_o = hold_ff;

endmodule

`default_nettype wire

// ==== core/ims_top.v ====
// Interrupt mode selection, masking, priority encoding and vector latching with an AXI4-Lite register port.
//
// Notes on behaviour
// - Compatibility mode when boot vector set, vector select clear, or spacing zero.
// - Vectored mode needs boot select 0, vector select 1, spacing nonzero, vectored present, no external.
// - External mode needs boot select 0, vector select 1, spacing nonzero, controller present.
// - Compatibility dispatch offset 0x180 when vector select is 0, 0x200 when 1.
// - Vectored mode presence always reads as one.
// - External controller presence follows a static system input.
// - Reset leaves the block in compatibility mode.
// - Spacing cannot hold nonzero when no optional mode exists.
// - Two software requests and eight hardware inputs; the timer arrives merged onto hardware line 5.
// - Pending AND mask, gated by enable with exception and error levels clear.
// - Vectored priority: hardware 7 highest to software 0, vectors 9 to 0.
// - Vector offset latched when request raised, stable if request withdrawn.
// - External mode exports software, timer, counter and debug request states.
`default_nettype none
`include "ims_regs.vh"

module ims_top #(
    parameter OPT_MODE_PRESENT = 1
) (
    // Clock and reset.
    input wire clk_i,
    input wire rstn_i,
    // Interrupt sources.
    input wire [7:0] hw_irq_i,
    input wire timer_irq_i,
    input wire perf_irq_i,
    input wire fdc_irq_i,
    input wire ext_ctrl_present_in_i,
    // Pipeline side.
    input wire irq_ack_i,
    output wire irq_req_o,
    output wire [11:0] vector_offset_o,
    output wire [1:0] mode_o,
    // Exports to the external controller.
    output wire [1:0] ext_sw_irq_o,
    output wire ext_timer_irq_o,
    output wire ext_perf_irq_o,
    output wire ext_fdc_irq_o,
    // Block interrupt.
    output wire irq_o,
    // AXI4-Lite slave.
    input wire [7:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    output wire [1:0] s_axi_bresp,
    output wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire [7:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    output wire [31:0] s_axi_rdata,
    output wire [1:0] s_axi_rresp,
    output wire s_axi_rvalid,
    input wire s_axi_rready
);

////////////////////////////////////////////////////////////////////////////////
reg rst_sync1_ff;
reg rst_sync2_ff;
wire rst_n;

always @(posedge clk_i or negedge rstn_i)
begin
    if (!rstn_i)
    begin
        rst_sync1_ff <= 1'b0;
        rst_sync2_ff <= 1'b0;
    end
    else
    begin
        rst_sync1_ff <= 1'b1;
        rst_sync2_ff <= rst_sync1_ff;
    end
end

assign rst_n = rst_sync2_ff;

////////////////////////////////////////////////////////////////////////////////
reg [4:0] ctrl_ff;
reg [4:0] spacing_ff;
reg [1:0] sw_pend_ff;
reg [9:0] mask_ff;
reg [1:0] irq_stat_ff;
reg [1:0] irq_mask_ff;
reg [1:0] prev_mode_ff;
reg req_ff;

wire boot_vector_select = ctrl_ff[`IMS_CTRL_BOOTSEL];
wire interrupt_vector_select = ctrl_ff[`IMS_CTRL_VECSEL];
wire global_int_enable = ctrl_ff[`IMS_CTRL_GLBEN];
wire exception_level = ctrl_ff[`IMS_CTRL_EXCLVL];
wire error_level = ctrl_ff[`IMS_CTRL_ERRLVL];
wire vectored_mode_present = 1'b1;
wire ext_ctrl_present = ext_ctrl_present_in_i;
wire spacing_nz = (spacing_ff != 5'h00);

// The timer is not folded in here; the system merges it onto hardware line 5.
wire [9:0] pending_interrupt_bits = {hw_irq_i, sw_pend_ff};

////////////////////////////////////////////////////////////////////////////////
reg [1:0] mode;

always @*
begin
    // Decoded every cycle so a field write affects the next evaluation.
    if (boot_vector_select || !interrupt_vector_select || !spacing_nz)
    begin
        mode = `IMS_MODE_COMPAT;
    end
    else if (ext_ctrl_present)
    begin
        mode = `IMS_MODE_EXT;
    end
    else if (vectored_mode_present)
    begin
        mode = `IMS_MODE_VECT;
    end
    else
    begin
        mode = `IMS_MODE_COMPAT;
    end
end

wire vectored_mode = (mode == `IMS_MODE_VECT);
wire external_ctrl_mode = (mode == `IMS_MODE_EXT);

wire [9:0] masked = pending_interrupt_bits & mask_ff;
wire int_enabled = global_int_enable && !exception_level && !error_level;
wire int_signal = (|masked) && int_enabled && !external_ctrl_mode;

reg [3:0] vec_num;
integer i;

always @*
begin
    vec_num = 4'h0;
    // Scan upward so the highest line overwrites lower ones.
    for (i = 0; i < 10; i = i + 1)
    begin
        if (masked[i])
        begin
            vec_num = i[3:0];
        end
    end
end

reg [11:0] offset_calc;

always @*
begin
    if (vectored_mode)
    begin
        // Vector spacing is in units of 32 bytes above the special vector.
        offset_calc = `IMS_VEC_SPECIAL + (({8'h00, vec_num} * {7'h00, spacing_ff}) << 5);
    end
    else if (interrupt_vector_select)
    begin
        offset_calc = `IMS_VEC_SPECIAL;
    end
    else
    begin
        offset_calc = `IMS_VEC_GENERAL;
    end
end

wire raise = int_signal && !req_ff;

ims_latch #(
    .WIDTH(12)
) i_ims_latch (
    .clk_i(clk_i),
    .rst_n_i(rst_n),
    .load_i(raise),
    .data_i(offset_calc),
    .data_o(vector_offset_o)
);

always @(posedge clk_i or negedge rst_n)
begin
    if (!rst_n)
    begin
        req_ff <= 1'b0;
    end
    else if (raise)
    begin
        req_ff <= 1'b1;
    end
    else if (irq_ack_i)
    begin
        req_ff <= 1'b0;
    end
end

assign irq_req_o = req_ff;
assign mode_o = mode;
assign ext_sw_irq_o = external_ctrl_mode ? sw_pend_ff : 2'h0;
assign ext_timer_irq_o = external_ctrl_mode & timer_irq_i;
assign ext_perf_irq_o = external_ctrl_mode & perf_irq_i;
assign ext_fdc_irq_o = external_ctrl_mode & fdc_irq_i;

////////////////////////////////////////////////////////////////////////////////
reg [7:0] awaddr_ff;
reg aw_have_ff;
reg [31:0] wdata_ff;
reg [3:0] wstrb_ff;
reg w_have_ff;
reg bvalid_ff;
reg [1:0] bresp_ff;
reg rvalid_ff;
reg [31:0] rdata_ff;
reg [1:0] rresp_ff;

assign s_axi_awready = !aw_have_ff && !bvalid_ff;
assign s_axi_wready = !w_have_ff && !bvalid_ff;
assign s_axi_bvalid = bvalid_ff;
assign s_axi_bresp = bresp_ff;
assign s_axi_arready = !rvalid_ff;
assign s_axi_rvalid = rvalid_ff;
assign s_axi_rdata = rdata_ff;
assign s_axi_rresp = rresp_ff;

wire do_write = aw_have_ff && w_have_ff && !bvalid_ff;
wire wr_ctrl = do_write && (awaddr_ff == `IMS_OFF_CTRL) && wstrb_ff[0];
wire wr_spc = do_write && (awaddr_ff == `IMS_OFF_SPACING) && wstrb_ff[0];
wire wr_pend = do_write && (awaddr_ff == `IMS_OFF_PEND) && wstrb_ff[0];
wire wr_mask = do_write && (awaddr_ff == `IMS_OFF_MASK);
wire wr_istat = do_write && (awaddr_ff == `IMS_OFF_IRQ_STAT) && wstrb_ff[0];
wire wr_imask = do_write && (awaddr_ff == `IMS_OFF_IRQ_MASK) && wstrb_ff[0];
wire wr_known = (awaddr_ff <= `IMS_OFF_IRQ_MASK) && (awaddr_ff[1:0] == 2'h0);

always @(posedge clk_i or negedge rst_n)
begin
    if (!rst_n)
    begin
        awaddr_ff <= 8'h00;
        aw_have_ff <= 1'b0;
        wdata_ff <= 32'h00000000;
        wstrb_ff <= 4'h0;
        w_have_ff <= 1'b0;
        bvalid_ff <= 1'b0;
        bresp_ff <= 2'h0;
    end
    else
    begin
        if (s_axi_awvalid && s_axi_awready)
        begin
            awaddr_ff <= s_axi_awaddr;
            aw_have_ff <= 1'b1;
        end
        if (s_axi_wvalid && s_axi_wready)
        begin
            wdata_ff <= s_axi_wdata;
            wstrb_ff <= s_axi_wstrb;
            w_have_ff <= 1'b1;
        end
        if (do_write)
        begin
            aw_have_ff <= 1'b0;
            w_have_ff <= 1'b0;
            bvalid_ff <= 1'b1;
            bresp_ff <= wr_known ? 2'h0 : 2'h3;
        end
        else if (bvalid_ff && s_axi_bready)
        begin
            bvalid_ff <= 1'b0;
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
wire [1:0] events;
assign events[`IMS_EV_RAISE] = raise;
assign events[`IMS_EV_MODECHG] = (mode != prev_mode_ff);

always @(posedge clk_i or negedge rst_n)
begin
    if (!rst_n)
    begin
        ctrl_ff <= `IMS_CTRL_RST;
        spacing_ff <= 5'h00;
        sw_pend_ff <= 2'h0;
        mask_ff <= 10'h000;
        irq_mask_ff <= 2'h0;
        irq_stat_ff <= 2'h0;
        prev_mode_ff <= `IMS_MODE_COMPAT;
    end
    else
    begin
        prev_mode_ff <= mode;
        if (wr_ctrl)
        begin
            ctrl_ff <= wdata_ff[4:0];
        end
        if (wr_spc)
        begin
            // Spacing stays zero without an optional mode present.
            spacing_ff <= (OPT_MODE_PRESENT != 0) ? wdata_ff[4:0] : 5'h00;
        end
        if (wr_pend)
        begin
            sw_pend_ff <= wdata_ff[1:0];
        end
        if (wr_mask)
        begin
            mask_ff <= wdata_ff[9:0];
        end
        if (wr_imask)
        begin
            irq_mask_ff <= wdata_ff[1:0];
        end
        // A new event wins over a simultaneous write-one clear.
        irq_stat_ff <= (irq_stat_ff & ~(wr_istat ? wdata_ff[1:0] : 2'h0)) | events;
    end
end

assign irq_o = |(irq_stat_ff & irq_mask_ff);

////////////////////////////////////////////////////////////////////////////////
reg [31:0] rd_mux;
reg rd_ok;

always @*
begin
    rd_ok = 1'b1;
    case (s_axi_araddr)
        `IMS_OFF_CTRL: rd_mux = {27'h0, ctrl_ff};
        `IMS_OFF_SPACING: rd_mux = {27'h0, spacing_ff};
        `IMS_OFF_PEND: rd_mux = {22'h0, pending_interrupt_bits};
        `IMS_OFF_MASK: rd_mux = {22'h0, mask_ff};
        `IMS_OFF_MODE: rd_mux = {28'h0, ext_ctrl_present, vectored_mode_present, mode};
        `IMS_OFF_VECTOR: rd_mux = {15'h0, req_ff, vec_num, vector_offset_o};
        `IMS_OFF_IRQ_STAT: rd_mux = {30'h0, irq_stat_ff};
        `IMS_OFF_IRQ_MASK: rd_mux = {30'h0, irq_mask_ff};
        default:
        begin
            rd_mux = 32'h00000000;
            rd_ok = 1'b0;
        end
    endcase
end

always @(posedge clk_i or negedge rst_n)
begin
    if (!rst_n)
    begin
        rvalid_ff <= 1'b0;
        rdata_ff <= 32'h00000000;
        rresp_ff <= 2'h0;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
        rvalid_ff <= 1'b1;
        rdata_ff <= rd_mux;
        rresp_ff <= rd_ok ? 2'h0 : 2'h3;
    end
    else if (rvalid_ff && s_axi_rready)
    begin
        rvalid_ff <= 1'b0;
    end
end

endmodule

`default_nettype wire

// ==== dv/ims_src.sv ====
// Model of the system interrupt sources around the block.
`default_nettype none
module ims_src (
    // From the bench.
    input wire logic [7:0] line_i,
    input wire logic tick_i,
    input wire logic ext_i,
    // Into the block.
    output logic [7:0] hw_irq_o,
    output logic timer_irq_o,
    output logic ext_ctrl_present_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // A plain OR is the cheapest merge, so the timer looks like line five.
    assign hw_irq_o = {line_i[7:6], line_i[5] | tick_i, line_i[4:0]};
    assign timer_irq_o = tick_i;
    assign ext_ctrl_present_o = ext_i;
endmodule
`default_nettype wire

// ==== dv/ims_sva.sv ====
// Checker for mode decode, request latching and exports.
`default_nettype none
module ims_sva (
    // Clock and reset.
    input wire logic clk_i,
    input wire logic rstn_i,
    // Watched ports.
    input wire logic ext_ctrl_present_in_i,
    input wire logic timer_irq_i,
    input wire logic perf_irq_i,
    input wire logic fdc_irq_i,
    input wire logic irq_ack_i,
    input wire logic irq_req_o,
    input wire logic [11:0] vector_offset_o,
    input wire logic [1:0] mode_o,
    input wire logic [1:0] ext_sw_irq_o,
    input wire logic ext_timer_irq_o,
    input wire logic ext_perf_irq_o,
    input wire logic ext_fdc_irq_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk_i);
    endclocking
    default disable iff (!rstn_i);
    rst_mode_a: assert property ($rose(rstn_i) |-> mode_o == 2'h0)
        else $error("mode after reset");
    mode_code_a: assert property (mode_o != 2'h3)
        else $error("bad mode code");
    vect_mode_a: assert property (mode_o == 2'h1 |-> !ext_ctrl_present_in_i)
        else $error("vectored with controller");
    ext_mode_a: assert property (mode_o == 2'h2 |-> ext_ctrl_present_in_i)
        else $error("external without controller");
    compat_vec_a: assert property ($rose(irq_req_o) && $past(mode_o) == 2'h0 |->
        vector_offset_o == 12'h180 || vector_offset_o == 12'h200) else $error("compat offset");
    vec_hold_a: assert property (irq_req_o && $past(irq_req_o) |-> $stable(vector_offset_o))
        else $error("offset moved");
    ack_clear_a: assert property (irq_req_o && irq_ack_i |=> !irq_req_o)
        else $error("ack ignored");
    ext_export_a: assert property (mode_o == 2'h2 |-> {ext_timer_irq_o, ext_perf_irq_o, ext_fdc_irq_o} ==
        {timer_irq_i, perf_irq_i, fdc_irq_i}) else $error("export wrong");
    ext_quiet_a: assert property (mode_o != 2'h2 |->
        {ext_sw_irq_o, ext_timer_irq_o, ext_perf_irq_o, ext_fdc_irq_o} == 5'h00) else $error("export leak");
    ext_noreq_a: assert property (mode_o == 2'h2 && !irq_req_o |=> !irq_req_o)
        else $error("request in external mode");
    cover property (mode_o == 2'h1);
    cover property (mode_o == 2'h2);
    cover property ($rose(irq_req_o));
endmodule
`default_nettype wire

// ==== dv/ims_top_test.sv ====
// Self-checking bench for the interrupt mode select block.
`default_nettype none
module ims_top_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i = 1'b0;
    logic rstn_i = 1'b0;
    logic tick = 1'b0, ext = 1'b0, perf = 1'b0, fdc = 1'b0, ack = 1'b0;
    logic awv = 1'b0, wv = 1'b0, arv = 1'b0;
    logic [7:0] line = 8'h00, aw = 8'h00, ar = 8'h00;
    logic [31:0] wd = 32'h0, rdat;
    logic [1:0] resp;
    int fail_count = 0, cmp_count = 0;
    wire [7:0] hw;
    wire timer, extp, awr, wrdy, bv, arr, rv, req, irq, et, ep, ef;
    wire [1:0] br, rr, mode, esw;
    wire [11:0] voff;
    wire [31:0] rdw;
    ////////////////////////////////////////////////////////////////
    ims_src i_ims_src (.line_i(line), .tick_i(tick), .ext_i(ext), .hw_irq_o(hw), .timer_irq_o(timer),
        .ext_ctrl_present_o(extp));
    ims_top i_ims_top (.clk_i(clk_i), .rstn_i(rstn_i), .hw_irq_i(hw), .timer_irq_i(timer), .perf_irq_i(perf),
        .fdc_irq_i(fdc), .ext_ctrl_present_in_i(extp), .irq_ack_i(ack), .irq_req_o(req), .vector_offset_o(voff),
        .mode_o(mode), .ext_sw_irq_o(esw), .ext_timer_irq_o(et), .ext_perf_irq_o(ep), .ext_fdc_irq_o(ef),
        .irq_o(irq), .s_axi_awaddr(aw), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
        .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wrdy), .s_axi_bresp(br), .s_axi_bvalid(bv),
        .s_axi_bready(1'b1), .s_axi_araddr(ar), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdw),
        .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(1'b1));
    always #5 clk_i = ~clk_i;
    ////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        cmp_count++;
        if (g !== e)
        begin
            fail_count++;
            $display("[ERR] %0t got %h want %h", $time, g, e);
        end
    endtask
    task automatic finish_test();
        $display("mismatches %0d compares %0d", fail_count, cmp_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic tmo(input int n);
        if (n > 50)
        begin
            fail_count++;
            $display("[ERR] %0t wait ran out", $time);
            finish_test();
        end
    endtask
    // Ready is sampled mid-cycle, so valid drops only at the edge that took it.
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic ra, rw, rb;
        int n;
        @(posedge clk_i);
        aw <= a;
        wd <= d;
        awv <= 1'b1;
        wv <= 1'b1;
        n = 0;
        rb = 1'b0;
        while (!rb)
        begin
            @(negedge clk_i);
            ra = awr;
            rw = wrdy;
            rb = bv;
            resp = br;
            @(posedge clk_i);
            if (ra)
                awv <= 1'b0;
            if (rw)
                wv <= 1'b0;
            n++;
            tmo(n);
        end
    endtask
    task automatic rc(input logic [7:0] a, input logic [31:0] e);
        logic ra, rb;
        int n;
        @(posedge clk_i);
        ar <= a;
        arv <= 1'b1;
        n = 0;
        rb = 1'b0;
        while (!rb)
        begin
            @(negedge clk_i);
            ra = arr;
            rb = rv;
            rdat = rdw;
            resp = rr;
            @(posedge clk_i);
            if (ra)
                arv <= 1'b0;
            n++;
            tmo(n);
        end
        chk(rdat, e);
    endtask
    task automatic wreq();
        int n;
        n = 0;
        @(negedge clk_i);
        while (req !== 1'b1)
        begin
            @(negedge clk_i);
            n++;
            tmo(n);
        end
    endtask
    task automatic pulse_ack();
        @(posedge clk_i);
        ack <= 1'b1;
        @(posedge clk_i);
        ack <= 1'b0;
    endtask
    ////////////////////////////////////////////////////////////////
    initial
    begin
        logic [1:0] m;
        logic [31:0] e;
        int vec;
        repeat (5) @(posedge clk_i);
        rstn_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        rc(8'h00, 32'h1);
        rc(8'h10, 32'h4);
        for (int i = 0; i < 16; i++)
        begin
            ext <= i[3];
            wr(8'h00, {30'h0, i[1:0]});
            wr(8'h04, {31'h0, i[2]});
            m = (i[0] || !i[1] || !i[2]) ? 2'h0 : (i[3] ? 2'h2 : 2'h1);
            @(negedge clk_i);
            chk({30'h0, mode}, {30'h0, m});
            rc(8'h10, {28'h0, i[3], 1'b1, m});
        end
        rc(8'h18, 32'h2);
        chk({31'h0, irq}, 32'h0);
        wr(8'h1C, 32'h2);
        chk({31'h0, irq}, 32'h1);
        wr(8'h18, 32'h2);
        chk({31'h0, irq}, 32'h0);
        wr(8'h1C, 32'h0);
        wr(8'h40, 32'h1);
        chk({30'h0, resp}, 32'h3);
        rc(8'h40, 32'h0);
        chk({30'h0, resp}, 32'h3);
        ext <= 1'b0;
        wr(8'h04, 32'h0);
        wr(8'h0C, 32'h3FF);
        wr(8'h08, 32'h1);
        line <= 8'h01;
        tick <= 1'b1;
        rc(8'h08, 32'h85);
        line <= 8'h00;
        tick <= 1'b0;
        for (int v = 0; v < 2; v++)
        begin
            wr(8'h00, (v ? 32'h14 : 32'h0C) | (v << 1));
            @(negedge clk_i);
            chk({31'h0, req}, 32'h0);
            wr(8'h00, 32'h04 | (v << 1));
            wreq();
            chk({20'h0, voff}, v ? 32'h200 : 32'h180);
            wr(8'h00, 32'h0);
            pulse_ack();
        end
        wr(8'h04, 32'h1);
        for (int k = 0; k < 3; k++)
        begin
            line <= (k == 0) ? 8'h88 : (k == 1) ? 8'h08 : 8'h00;
            vec = (k == 0) ? 9 : (k == 1) ? 5 : 0;
            e = 32'h200 + vec * 32;
            wr(8'h00, 32'h06);
            wreq();
            chk({20'h0, voff}, e);
            rc(8'h14, 32'h10000 | (vec << 12) | e);
            line <= 8'h00;
            repeat (3) @(negedge clk_i);
            chk({20'h0, voff}, e);
            wr(8'h00, 32'h0);
            pulse_ack();
        end
        ext <= 1'b1;
        tick <= 1'b1;
        perf <= 1'b1;
        fdc <= 1'b1;
        wr(8'h00, 32'h06);
        repeat (2) @(negedge clk_i);
        chk({27'h0, esw, et, ep, ef}, 32'h0F);
        chk({29'h0, mode, req}, 32'h4);
        finish_test();
    end
endmodule

bind ims_top ims_sva i_ims_sva (.clk_i, .rstn_i, .ext_ctrl_present_in_i, .timer_irq_i, .perf_irq_i,
    .fdc_irq_i, .irq_ack_i, .irq_req_o, .vector_offset_o, .mode_o, .ext_sw_irq_o, .ext_timer_irq_o,
    .ext_perf_irq_o, .ext_fdc_irq_o);
`default_nettype wire
